/* bench/acc_core_model.sv */
// Behavioural converter core answering with channel, reference and a pattern
`timescale 1ns/1ps
module acc_core_model (
	// Clock and control
	input  wire logic       clk_i,
	input  wire logic       on_i,
	input  wire logic [2:0] channel_i,
	input  wire logic [1:0] reference_i,
	input  wire logic [4:0] pat_i,
	// Result
	output logic      [9:0] data_o
);
	logic [9:0] last_q = 10'h000;
	// Remember the last answer so an unpowered core never shows it
	always @(posedge clk_i) begin
		if (on_i) begin
			last_q <= {channel_i, reference_i, pat_i};
		end
	end
	// Unpowered core drives the inverse, not a stale but plausible value
	assign data_o = on_i ? {channel_i, reference_i, pat_i} : ~last_q;
endmodule

/* bench/comparator_and_adc_control_test.sv */
// Self-checking bench for the comparator and converter control
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin num_errors++; \
	$display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module comparator_and_adc_control_test;
	logic       clk_i = 1'b0, rst_b_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, gie_i = 1'b0;
	logic       cmp_vec_ack_i = 1'b0, conv_vec_ack_i = 1'b0, cmp_out_i = 1'b0, ce_i = 1'b1;
	logic       power_reduce_i = 1'b0, cmp_irq_o, conv_irq_o, comparator_power_off_o;
	logic       bandgap_positive_select_o, neg_from_mux_o, capture_o, conv_on_o, conv_sample_o;
	logic [2:0] addr_i = 3'h0, neg_channel_o, conv_channel_o;
	logic [7:0] wdata_i = 8'h00, trig_i = 8'h00, rdata_o, d;
	logic [1:0] pin_raw_i = 2'h0, pin_buf_off_o, pin_in_o, conv_reference_o;
	logic [9:0] conv_data_i;
	logic [4:0] pat = 5'h00;
	int         num_errors = 0, comparisons = 0, cycles = 0, samples = 0;

	// Design and core model
	acc_top #(.AW(3)) i_acc_top (.clk_i, .rst_b_i, .ce_i, .addr_i, .wdata_i, .wr_i, .rd_i,
		.rdata_o, .gie_i, .cmp_vec_ack_i, .conv_vec_ack_i, .cmp_irq_o, .conv_irq_o, .cmp_out_i,
		.comparator_power_off_o, .bandgap_positive_select_o, .neg_from_mux_o, .neg_channel_o,
		.capture_o, .pin_raw_i, .pin_buf_off_o, .pin_in_o, .power_reduce_i, .trig_i,
		.conv_data_i, .conv_on_o, .conv_sample_o, .conv_channel_o, .conv_reference_o);
	acc_core_model i_acc_core_model (.clk_i, .on_i(conv_on_o), .channel_i(conv_channel_o),
		.reference_i(conv_reference_o), .pat_i(pat), .data_o(conv_data_i));

	// Clock and hang guard
	always #5 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cycles++;
		if (conv_sample_o === 1'b1) samples++;
		if (cycles == 20000) begin
			num_errors++;
			finish_test();
		end
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// Register port: one-cycle strobes, read data in the following cycle
	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask
	// Poll the start bit, bounded
	task automatic wait_idle();
		d = 8'h40;
		for (int n = 0; n < 200 && d[6] === 1'b1; n++) rd(3'h2);
		`CHK(d[6], 1'b0)
	endtask
	task automatic chk_res(input logic [9:0] v, input logic left);
		rd(3'h5);
		`CHK(d, left ? {v[1:0], 6'h00} : v[7:0])
		rd(3'h6);
		`CHK(d, left ? v[9:2] : {6'h00, v[9:8]})
	endtask
	function automatic logic flag_exp(input logic [1:0] m, input logic up);
		return m == 2'h0 || (m == 2'h3 && up) || (m == 2'h2 && !up);
	endfunction
	task automatic finish_test();
		$display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		logic [7:0] r;
		logic [9:0] v;
		logic       left;
		r = 8'($urandom(82));
		cyc(20);
		rst_b_i <= 1'b1;
		// Reset values, unmapped write ignored
		wr(3'h7, 8'hFF);
		for (int a = 0; a < 8; a++) begin
			rd(3'(a));
			`CHK(d, 8'h00)
		end
		// Clock enable low freezes the registers
		ce_i <= 1'b0;
		wr(3'h4, 8'hA5);
		ce_i <= 1'b1;
		rd(3'h4);
		`CHK(d, 8'h00)
		$display("reset test done");
		// Every mode on a rise and a fall; interrupt stays masked while mode changes
		for (int m = 0; m < 4; m++) begin
			wr(3'h0, 8'h10 | 8'(m));
			cmp_out_i <= 1'b1;
			cyc(5);
			rd(3'h0);
			`CHK(d[5:4], {1'b1, flag_exp(2'(m), 1'b1)})
			wr(3'h0, 8'h10 | 8'(m));
			cmp_out_i <= 1'b0;
			cyc(5);
			rd(3'h0);
			`CHK(d[5:4], {1'b0, flag_exp(2'(m), 1'b0)})
		end
		wr(3'h0, 8'h18);
		cmp_out_i <= 1'b1;
		cyc(5);
		`CHK(cmp_irq_o, 1'b0)
		gie_i <= 1'b1;
		cyc(1);
		#1 `CHK(cmp_irq_o, 1'b1)
		cmp_vec_ack_i <= 1'b1;
		cyc(1);
		cmp_vec_ack_i <= 1'b0;
		cyc(1);
		#1 `CHK(cmp_irq_o, 1'b0)
		cmp_out_i <= 1'b0;
		cyc(5);
		wr(3'h0, 8'h00);
		#1 `CHK(cmp_irq_o, 1'b0)
		$display("comparator flag test done");
		// Random routing, mux and pin buffer settings
		for (int i = 0; i < 4; i++) begin
			r = 8'($urandom);
			v = 10'($urandom);
			cmp_out_i <= r[3];
			pin_raw_i <= v[9:8];
			wr(3'h0, r & 8'hE7);
			wr(3'h3, {1'b0, r[5], 6'h00});
			wr(3'h2, {r[1], 7'h00});
			wr(3'h4, {5'h00, v[4:2]});
			wr(3'h1, {6'h00, v[1:0]});
			cyc(3);
			`CHK(comparator_power_off_o, r[7])
			`CHK(bandgap_positive_select_o, r[6])
			`CHK(capture_o, r[2] & r[3])
			`CHK(neg_from_mux_o, r[5] & ~r[1])
			`CHK(neg_channel_o, v[4:2])
			`CHK(pin_buf_off_o, v[1:0])
			`CHK(pin_in_o, v[9:8] & ~v[1:0])
		end
		wr(3'h0, 8'h00);
		wr(3'h3, 8'h00);
		$display("routing test done");
		// Selections reach the converter only while enabled
		wr(3'h2, 8'h80);
		wr(3'h4, 8'h45);
		wr(3'h2, 8'h00);
		wr(3'h4, 8'h82);
		cyc(2);
		`CHK({conv_reference_o, conv_channel_o}, 5'h0D)
		power_reduce_i <= 1'b1;
		wr(3'h2, 8'h80);
		#1 `CHK(conv_on_o, 1'b0)
		power_reduce_i <= 1'b0;
		wr(3'h2, 8'h80);
		cyc(2);
		`CHK({conv_on_o, conv_reference_o, conv_channel_o}, 6'h32)
		$display("selection test done");
		// Single conversions, channel rewritten mid-conversion
		for (int i = 0; i < 3; i++) begin
			left = 1'($urandom);
			v = 10'($urandom);
			pat <= v[4:0];
			wr(3'h4, {v[6:5], left, 2'h0, v[9:7]});
			wr(3'h2, 8'hD0);
			wr(3'h4, {~v[6:5], left, 2'h0, ~v[9:7]});
			rd(3'h2);
			`CHK(d[6], 1'b1)
			wait_idle();
			chk_res(v, left);
			`CHK(conv_channel_o, ~v[9:7])
			`CHK(samples, i + 1)
		end
		// Low read locks; the next result is dropped but still flagged
		rd(3'h5);
		pat <= ~v[4:0];
		wr(3'h2, 8'hD8);
		wait_idle();
		rd(3'h2);
		`CHK({d[4], conv_irq_o}, 2'h3)
		rd(3'h6);
		`CHK(d, left ? v[9:2] : {6'h00, v[9:8]})
		chk_res(v, left);
		$display("conversion test done");
		// Auto trigger: start bit still works, edge starts, busy edge and held level do not
		wr(3'h3, 8'h03);
		wr(3'h2, 8'hF0);
		rd(3'h2);
		`CHK(d[6], 1'b1)
		wait_idle();
		trig_i <= {4'($urandom), 4'h8};
		cyc(4);
		rd(3'h2);
		`CHK(d[6], 1'b1)
		trig_i[3] <= 1'b0;
		cyc(2);
		trig_i[3] <= 1'b1;
		wait_idle();
		cyc(80);
		rd(3'h2);
		`CHK(d[6], 1'b0)
		trig_i <= 8'h00;
		$display("auto trigger test done");
		// Free run from the own done flag, first start by software
		wr(3'h3, 8'h00);
		wr(3'h2, 8'hF0);
		d = 8'h00;
		for (int n = 0; n < 100 && d[4] !== 1'b1; n++) rd(3'h2);
		cyc(4);
		rd(3'h2);
		`CHK(d[6], 1'b1)
		wr(3'h2, 8'h10);
		$display("free run test done");
		finish_test();
	end
endmodule

/* include/acc_cfg.svh */
// Register map, field positions, reset values and counts for the comparator and converter control
// ************************************************************
// Function
// - Disable bit powers the comparator off
// - Bandgap select picks comparator positive input
// - Result bit is synchronized comparator output
// - Mode-matched event sets flag; vector/W1C clear
// - Request needs local and global enable
// - Capture routing feeds comparator to timer
// - Mode field: toggle, reserved, fall, rise
// - Mux enable with converter off picks channel
// - Pin disable kills buffer, input reads zero
// - Channel and reference act only when enabled
// - Result right adjusted, left when aligned
// - Low read locks results until high read
// - Done flag rises even for dropped result
// - Start bit reads one while converting
// - Channel change waits for conversion end
// - Trigger edge resets prescaler and starts
// - Held trigger or busy edge starts nothing
// - Trigger flags set even when masked
// - Own done flag trigger runs freely
// - Start bit works with auto trigger
// - Conversion lasts 13, first one 25
// - Prescaler runs only while enabled
// ************************************************************
`ifndef ACC_CFG_SVH
`define ACC_CFG_SVH

// Register offsets
`define ACC_OFS_CMP     3'h0
`define ACC_OFS_DIS     3'h1
`define ACC_OFS_CTA     3'h2
`define ACC_OFS_CTB     3'h3
`define ACC_OFS_CHR     3'h4
`define ACC_OFS_RLO     3'h5
`define ACC_OFS_RHI     3'h6

// Comparator control and status fields
`define ACC_CMP_OFF     7
`define ACC_CMP_BG      6
`define ACC_CMP_RES     5
`define ACC_CMP_FLAG    4
`define ACC_CMP_IE      3
`define ACC_CMP_CAP     2
`define ACC_CMP_MODE_HI 1
`define ACC_CMP_MODE_LO 0
`define ACC_MODE_TOGGLE 2'h0
`define ACC_MODE_RSVD   2'h1
`define ACC_MODE_FALL   2'h2
`define ACC_MODE_RISE   2'h3

// Pin input disable fields
`define ACC_DIS_NEG     1
`define ACC_DIS_POS     0

// Converter control fields
`define ACC_CTA_EN      7
`define ACC_CTA_START   6
`define ACC_CTA_AUTO    5
`define ACC_CTA_FLAG    4
`define ACC_CTA_IE      3
`define ACC_CTA_PS_HI   2
`define ACC_CTB_MUX     6
`define ACC_CTB_TS_HI   2
`define ACC_CHR_REF_HI  7
`define ACC_CHR_REF_LO  6
`define ACC_CHR_LEFT    5
`define ACC_CHR_CH_HI   2
`define ACC_TRIG_SELF   3'h0

// Reset values and counts
`define ACC_RST_BYTE    8'h00
`define ACC_PAD6        6'h00
`define ACC_LEN_NORMAL  5'h0D
`define ACC_LEN_FIRST   5'h19
`define ACC_PS_MIN      3'h1

`endif

/* include/acc_conv_if.sv */
`timescale 1ns/1ps
// Control and status between the register file and the conversion sequencer
interface acc_conv_if;
	logic       en;      // Converter powered and clocked
	logic       start;   // One-cycle software start
	logic       trig;    // One-cycle trigger edge
	logic       restart; // Relaunch at completion
	logic [2:0] ps;      // Prescaler select
	logic       busy;    // Start pending or converting
	logic       done;    // One-cycle completion pulse
	logic       sample;  // One-cycle launch toward the core
	modport ctl (output en, start, trig, restart, ps, input busy, done, sample);
	modport seq (input en, start, trig, restart, ps, output busy, done, sample);
endinterface

/* include/acc_pkg.sv */
// Types shared by the comparator and converter control modules
package acc_pkg;
	// Sequencer states, Gray along idle, armed, busy
	typedef enum logic [1:0] {
		ST_IDLE  = 2'h0,
		ST_ARMED = 2'h1,
		ST_BUSY  = 2'h3
	} acc_seq_t;
	typedef logic [9:0] acc_result_t;
endpackage

/* rtl/acc_cmp_sync.sv */
`timescale 1ns/1ps
// Comparator output synchronizer and edge detector
module acc_cmp_sync (
	// Clock, reset, enable
	input  wire logic clk_i,
	input  wire logic rst_b_i,
	input  wire logic ce_i,
	// Comparator
	input  wire logic raw_i,
	output logic      res_o,
	output logic      rise_o,
	output logic      fall_o
);
	logic s1_q;
	logic res_q;
	logic prev_q;

	// Two stages; only the second is ever looked at
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			s1_q   <= 1'b0;
			res_q  <= 1'b0;
			prev_q <= 1'b0;
		end else if (ce_i) begin
			s1_q   <= raw_i;
			res_q  <= s1_q;
			prev_q <= res_q;
		end
	end

	// Edges are pulses only while clocked
	assign res_o  = res_q;
	assign rise_o = ce_i & res_q & ~prev_q;
	assign fall_o = ce_i & ~res_q & prev_q;

	sync_lat_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		$past(ce_i) && ce_i |=> res_o == $past(raw_i, 2))
		else $error("comparator result not two cycles behind input");
endmodule

/* rtl/acc_conv_seq.sv */
`timescale 1ns/1ps
`include "acc_cfg.svh"
// Converter prescaler and conversion sequencer
module acc_conv_seq #(
	parameter int PS_W = 7
) (
	// Clock, reset, enable
	input  wire logic clk_i,
	input  wire logic rst_b_i,
	input  wire logic ce_i,
	// Control
	acc_conv_if.seq   cv
);
	acc_pkg::acc_seq_t st_q, st_d;
	logic [PS_W-1:0]   pre_q;
	logic [4:0]        cyc_q;
	logic              first_q;

	// Prescaler terminal count and conversion length
	wire [2:0]      ps_eff = (cv.ps < `ACC_PS_MIN) ? `ACC_PS_MIN : cv.ps;
	wire [PS_W-1:0] top    = PS_W'((8'h01 << ps_eff) - 8'h01);
	wire            tick   = (pre_q == top);
	wire [4:0]      last_c = (first_q ? `ACC_LEN_FIRST : `ACC_LEN_NORMAL) - 5'h01;
	wire            last   = (st_q == acc_pkg::ST_BUSY) && tick && (cyc_q == last_c);

	assign cv.busy   = (st_q != acc_pkg::ST_IDLE);
	assign cv.done   = ce_i & last;
	assign cv.sample = ce_i & tick & ((st_q == acc_pkg::ST_ARMED) | (last & cv.restart)); // Free run too

	// Next state; free running stays busy across completion
	always_comb begin
		st_d = st_q;
		unique case (st_q)
			acc_pkg::ST_IDLE:  if (cv.start || cv.trig) st_d = acc_pkg::ST_ARMED;
			acc_pkg::ST_ARMED: if (tick) st_d = acc_pkg::ST_BUSY;
			acc_pkg::ST_BUSY:  if (last && !cv.restart) st_d = acc_pkg::ST_IDLE;
			default:           st_d = acc_pkg::ST_IDLE;
		endcase
		if (!cv.en) st_d = acc_pkg::ST_IDLE;
	end

	// Prescaler held at zero when off, cleared on a trigger
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) pre_q <= '0;
		else if (ce_i) pre_q <= (!cv.en || cv.trig || tick) ? '0 : pre_q + 1'b1;
	end

	// State, cycle count and first-conversion marker
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			st_q    <= acc_pkg::ST_IDLE;
			cyc_q   <= 5'h00;
			first_q <= 1'b1;
		end else if (ce_i) begin
			st_q    <= st_d;
			cyc_q   <= (st_q != acc_pkg::ST_BUSY || last) ? 5'h00 : cyc_q + 5'(tick);
			first_q <= !cv.en || (first_q && !last);
		end
	end

	conv_len_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		st_q == acc_pkg::ST_BUSY |-> cyc_q <= last_c)
		else $error("conversion ran past its length");
	presc_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		ce_i && !cv.en |=> pre_q == '0)
		else $error("prescaler ran while converter off");
endmodule

/* rtl/acc_top.sv */
`timescale 1ns/1ps
`include "acc_cfg.svh"
// Comparator and converter control: register file, flags, routing, result lock
module acc_top #(
	parameter int AW = 3
) (
	// Clock, reset and clock enable
	input  wire logic          clk_i,
	input  wire logic          rst_b_i,
	input  wire logic          ce_i,
	// Register port
	input  wire logic [AW-1:0] addr_i,
	input  wire logic [7:0]    wdata_i,
	input  wire logic          wr_i,
	input  wire logic          rd_i,
	output logic      [7:0]    rdata_o,
	// Interrupt controller side
	input  wire logic          gie_i,
	input  wire logic          cmp_vec_ack_i,
	input  wire logic          conv_vec_ack_i,
	output logic               cmp_irq_o,
	output logic               conv_irq_o,
	// Comparator analog side
	input  wire logic          cmp_out_i,
	output logic               comparator_power_off_o,
	output logic               bandgap_positive_select_o,
	output logic               neg_from_mux_o,
	output logic      [2:0]    neg_channel_o,
	output logic               capture_o,
	// Comparator pin digital inputs
	input  wire logic [1:0]    pin_raw_i,
	output logic      [1:0]    pin_buf_off_o,
	output logic      [1:0]    pin_in_o,
	// Converter core
	input  wire logic          power_reduce_i,
	input  wire logic [7:0]    trig_i,
	input  wire logic [9:0]    conv_data_i,
	output logic               conv_on_o,
	output logic               conv_sample_o,
	output logic      [2:0]    conv_channel_o,
	output logic      [1:0]    conv_reference_o
);
	// ************************************************************
	// Declarations
	// ************************************************************
	acc_conv_if cv ();

	logic [7:0]           cmp_ctl_q;
	logic [1:0]           dis_q;
	logic [7:0]           cta_q;
	logic [7:0]           ctb_q;
	logic [7:0]           chr_q;
	logic                 cmp_flag_q;
	logic                 conv_flag_q;
	logic                 lock_q;
	logic                 start_q;
	logic                 trig_q;
	logic                 capture_q;
	logic                 sample_q;
	logic [1:0]           pin_in_q;
	logic [2:0]           ch_q;
	logic [1:0]           ref_q;
	logic [7:0]           rdata_q;
	acc_pkg::acc_result_t result_q;
	logic                 cmp_res;
	logic                 cmp_rise;
	logic                 cmp_fall;

	// Address match, shared by read and write decode
	function automatic logic hit(input logic [AW-1:0] a, input logic [2:0] ofs);
		hit = (a == AW'(ofs));
	endfunction

	// ************************************************************
	// Bus decode
	// ************************************************************
	wire w_cmp = wr_i & hit(addr_i, `ACC_OFS_CMP);
	wire w_dis = wr_i & hit(addr_i, `ACC_OFS_DIS);
	wire w_cta = wr_i & hit(addr_i, `ACC_OFS_CTA);
	wire w_ctb = wr_i & hit(addr_i, `ACC_OFS_CTB);
	wire w_chr = wr_i & hit(addr_i, `ACC_OFS_CHR);
	wire r_lo  = rd_i & hit(addr_i, `ACC_OFS_RLO);
	wire r_hi  = rd_i & hit(addr_i, `ACC_OFS_RHI);

	// ************************************************************
	// Comparator
	// ************************************************************
	acc_cmp_sync u_cmp (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.ce_i    (ce_i),
		.raw_i   (cmp_out_i),
		.res_o   (cmp_res),
		.rise_o  (cmp_rise),
		.fall_o  (cmp_fall)
	);

	// Mode decode; the reserved code raises nothing
	wire [1:0] mode    = cmp_ctl_q[`ACC_CMP_MODE_HI:`ACC_CMP_MODE_LO];
	wire       cmp_evt = (mode == `ACC_MODE_TOGGLE) ? (cmp_rise | cmp_fall) :
	                     (mode == `ACC_MODE_FALL)   ? cmp_fall :
	                     (mode == `ACC_MODE_RISE)   ? cmp_rise : 1'b0;
	wire       cmp_clr = cmp_vec_ack_i | (w_cmp & wdata_i[`ACC_CMP_FLAG]);
	wire       cmp_ie  = cmp_ctl_q[`ACC_CMP_IE];

	// Comparator control; result and flag bits are stored here but read back from live state
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) cmp_ctl_q <= `ACC_RST_BYTE;
		else if (ce_i && w_cmp) cmp_ctl_q <= wdata_i;
	end

	// Event flag; a new event beats a clear in the same cycle
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) cmp_flag_q <= 1'b0;
		else if (ce_i) cmp_flag_q <= cmp_evt | (cmp_flag_q & ~cmp_clr);
	end

	// Analog controls straight from the register bits
	assign comparator_power_off_o    = cmp_ctl_q[`ACC_CMP_OFF];
	assign bandgap_positive_select_o = cmp_ctl_q[`ACC_CMP_BG];
	assign cmp_irq_o = cmp_flag_q & cmp_ie & gie_i;

	// Negative input from the channel mux only with converter off
	assign neg_from_mux_o = ctb_q[`ACC_CTB_MUX] & ~cta_q[`ACC_CTA_EN];
	assign neg_channel_o  = chr_q[`ACC_CHR_CH_HI:0];

	// Capture path and pin inputs are registered to keep outputs clean
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			capture_q <= 1'b0;
			pin_in_q  <= 2'h0;
		end else if (ce_i) begin
			capture_q <= cmp_res & cmp_ctl_q[`ACC_CMP_CAP];
			pin_in_q  <= pin_raw_i & ~dis_q;
		end
	end
	assign capture_o     = capture_q;
	assign pin_in_o      = pin_in_q;
	assign pin_buf_off_o = dis_q;

	// Pin input disable register
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) dis_q <= 2'h0;
		else if (ce_i && w_dis) dis_q <= wdata_i[`ACC_DIS_NEG:`ACC_DIS_POS];
	end

	// ************************************************************
	// Converter control
	// ************************************************************
	// Power reduction keeps the converter off whatever software enables
	wire conv_en  = cta_q[`ACC_CTA_EN] & ~power_reduce_i;
	wire conv_bsy = cv.busy | start_q;
	wire [2:0] ts = ctb_q[`ACC_CTB_TS_HI:0];
	wire self_ts  = (ts == `ACC_TRIG_SELF);
	wire auto_en  = cta_q[`ACC_CTA_AUTO];
	// Start uses the written enable so one write can enable and start
	wire go       = w_cta & wdata_i[`ACC_CTA_START] & wdata_i[`ACC_CTA_EN] & ~power_reduce_i
	                & ~conv_bsy;
	wire trig_sel = trig_i[ts];
	// Only a fresh edge while idle counts; a level left high is ignored
	wire trig_edge = trig_sel & ~trig_q & auto_en & ~self_ts & ~conv_bsy;
	wire conv_clr  = conv_vec_ack_i | (w_cta & wdata_i[`ACC_CTA_FLAG]);

	assign cv.en      = conv_en;
	assign cv.start   = start_q;
	assign cv.trig    = trig_edge;
	assign cv.restart = auto_en & self_ts;
	assign cv.ps      = cta_q[`ACC_CTA_PS_HI:0];

	acc_conv_seq u_seq (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.ce_i    (ce_i),
		.cv      (cv.seq)
	);

	// Control register A; start and flag bits are live state
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) cta_q <= `ACC_RST_BYTE;
		else if (ce_i && w_cta) cta_q <= wdata_i;
	end

	// Control register B
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) ctb_q <= `ACC_RST_BYTE;
		else if (ce_i && w_ctb) ctb_q <= wdata_i;
	end

	// Channel and reference register as written by software
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) chr_q <= `ACC_RST_BYTE;
		else if (ce_i && w_chr) chr_q <= wdata_i;
	end

	// Start request and trigger history
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			start_q <= 1'b0;
			trig_q  <= 1'b0;
		end else if (ce_i) begin
			start_q <= go;
			trig_q  <= trig_sel;
		end
	end

	// Selection reaches the core only when enabled and not converting
	wire sel_upd = conv_en & (~cv.busy | cv.done);
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			ch_q  <= 3'h0;
			ref_q <= 2'h0;
		end else if (ce_i && sel_upd) begin
			ch_q  <= chr_q[`ACC_CHR_CH_HI:0];
			ref_q <= chr_q[`ACC_CHR_REF_HI:`ACC_CHR_REF_LO];
		end
	end
	assign conv_channel_o   = ch_q;
	assign conv_reference_o = ref_q;

	// Launch strobe toward the core
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) sample_q <= 1'b0;
		else if (ce_i) sample_q <= cv.sample;
	end
	assign conv_sample_o = sample_q;
	assign conv_on_o     = conv_en;

	// Done flag rises even when the result is dropped; set beats clear
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) conv_flag_q <= 1'b0;
		else if (ce_i) conv_flag_q <= cv.done | (conv_flag_q & ~conv_clr);
	end
	assign conv_irq_o = conv_flag_q & cta_q[`ACC_CTA_IE] & gie_i;

	// ************************************************************
	// Result registers and read lock
	// ************************************************************
	// Low read locks, high read frees; a result done in the low read's own cycle still lands and can tear the pair
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) lock_q <= 1'b0;
		else if (ce_i) lock_q <= r_lo | (lock_q & ~r_hi);
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) result_q <= '0;
		else if (ce_i && cv.done && !lock_q) result_q <= conv_data_i;
	end

	// Alignment is applied on read, so it may change after the fact
	wire       left = chr_q[`ACC_CHR_LEFT];
	wire [7:0] rlo  = left ? {result_q[1:0], `ACC_PAD6} : result_q[7:0];
	wire [7:0] rhi  = left ? result_q[9:2] : {`ACC_PAD6, result_q[9:8]};

	// ************************************************************
	// Read data
	// ************************************************************
	wire [7:0] cmp_rd = {cmp_ctl_q[7:6], cmp_res, cmp_flag_q, cmp_ctl_q[3:0]};
	wire [7:0] cta_rd = {cta_q[7], conv_bsy, cta_q[5], conv_flag_q, cta_q[3:0]};
	wire [7:0] rd_val = hit(addr_i, `ACC_OFS_CMP) ? cmp_rd :
	                    hit(addr_i, `ACC_OFS_DIS) ? {6'h00, dis_q} :
	                    hit(addr_i, `ACC_OFS_CTA) ? cta_rd :
	                    hit(addr_i, `ACC_OFS_CTB) ? ctb_q :
	                    hit(addr_i, `ACC_OFS_CHR) ? chr_q :
	                    hit(addr_i, `ACC_OFS_RLO) ? rlo :
	                    hit(addr_i, `ACC_OFS_RHI) ? rhi : 8'h00;

	// Data stands only in the cycle after the strobe
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) rdata_q <= 8'h00;
		else if (ce_i) rdata_q <= rd_i ? rd_val : 8'h00;
	end
	assign rdata_o = rdata_q;

	// ************************************************************
	// Checks
	// ************************************************************
	sequence s_go;
		(go && ce_i) ##1 (ce_i && conv_en);
	endsequence
	sequence s_locked_done;
		lock_q && !r_hi && cv.done;
	endsequence

	cmp_flag_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		cmp_evt && ce_i |=> cmp_flag_q)
		else $error("comparator event lost");
	mode_rsvd_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		ce_i && mode == `ACC_MODE_RSVD && !cmp_flag_q |=> !cmp_flag_q)
		else $error("reserved mode raised flag");
	mode_rise_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		ce_i && mode == `ACC_MODE_RISE && cmp_fall && !cmp_flag_q |=> !cmp_flag_q)
		else $error("falling edge flagged in rising mode");
	irq_gate_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(!cmp_ie || !gie_i) |-> !cmp_irq_o)
		else $error("comparator request without enables");
	neg_sel_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		cta_q[`ACC_CTA_EN] |-> !neg_from_mux_o)
		else $error("mux drove negative input with converter on");
	start_busy_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		s_go |=> cv.busy)
		else $error("start did not make converter busy");
	lock_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		s_locked_done and ce_i |=> $stable(result_q))
		else $error("locked result overwritten");
	done_flag_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		cv.done |=> conv_flag_q)
		else $error("done flag missing after conversion");
	trig_busy_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		conv_bsy |-> !cv.trig)
		else $error("trigger accepted while busy");
	pin_zero_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		ce_i && dis_q[0] |=> !pin_in_o[0])
		else $error("disabled pin read non-zero");
endmodule
